// ### logic/ddr_io_pkg.sv
// constants for the ddr i/o tristate, strobe and polarity block
package ddr_io_pkg;
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STAT_OFF = 8'h04;
    localparam int unsigned CTRL_W = 13;
    localparam int unsigned CTRL_DDR = 0;
    localparam int unsigned CTRL_LATCH = 1;
    localparam int unsigned CTRL_SRC_DQS = 2;
    localparam int unsigned CTRL_CLK_SEL = 3;
    localparam int unsigned CTRL_CLK_INV = 4;
    localparam int unsigned CTRL_CE_INV = 5;
    localparam int unsigned CTRL_LSR_INV = 6;
    localparam int unsigned CTRL_CE_SEL = 7;
    localparam int unsigned CTRL_LSR_SEL = 9;
    localparam int unsigned CTRL_HALF = 11;
    localparam int unsigned CTRL_DEF_POL = 12;
    localparam logic [12:0] CTRL_RST = 13'h0220;
    localparam int unsigned STAT_POL = 0;
    localparam int unsigned STAT_TRI = 1;
    localparam int unsigned STAT_WR = 2;
    localparam int unsigned STAT_GTS = 3;
    localparam int unsigned STAT_CODE = 8;
    localparam int unsigned STAT_CNT = 16;
    localparam int unsigned CODE_W = 6;
    localparam int unsigned I_RCLK = 0;
    localparam int unsigned I_CTL = 2;
    localparam int unsigned I_DQS = 6;
    localparam int unsigned I_IDLE = 7;
    localparam int unsigned I_GTS = 8;
    localparam int unsigned I_TNEG = 9;
    localparam int unsigned I_TPOS = 10;
    localparam int unsigned I_RD = 11;
    localparam int unsigned I_WPOS = 12;
    localparam int unsigned I_WNEG = 13;
    localparam int unsigned NSYNC = 14;
    localparam logic TRI_RST = 1'b1;
    localparam logic DQS_CAPABLE = 1'b1;
endpackage

// ### logic/ddr_io_tristate_dqs_polarity.sv
// ddr i/o cell: tristate register, control select, dqs strobe and read polarity
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module ddr_io_tristate_dqs_polarity
    import ddr_io_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] route_clk,
    input wire logic [3:0] route_ctl,
    input wire logic dqs_pad_in,
    input wire logic dqs_idle,
    input wire logic global_tristate_in,
    input wire logic tristate_neg_phase_in,
    input wire logic tristate_pos_phase_in,
    input wire logic rd_data_pad,
    input wire logic wr_data_pos,
    input wire logic wr_data_neg,
    input wire logic [5:0] dll_code_a,
    input wire logic [5:0] dll_code_b,
    output logic buffer_tristate_out,
    output logic global_tristate_out,
    output logic wr_data_out,
    output logic dqs_strobe_out,
    output logic [5:0] delay_code_out,
    output logic rd_sync_pos,
    output logic rd_sync_neg,
    output logic read_polarity,
    output logic preamble_pulse
);

    typedef struct packed {
        logic [NSYNC-1:0] s1;
        logic [NSYNC-1:0] s2;
        logic [CODE_W-1:0] c1;
        logic [CODE_W-1:0] c2;
        logic [CODE_W-1:0] cprev;
        logic [CODE_W-1:0] code;
        logic clk_prev;
        logic dqs_prev;
        logic idle_prev;
        logic sys_prev;
        logic tri_reg;
        logic tri_lat;
        logic tri_out;
        logic wr_reg;
        logic wr_lat;
        logic wr_out;
        logic in_pos;
        logic in_neg;
        logic sync_pos;
        logic sync_neg;
        logic pol;
        logic pre;
        logic gts;
        logic dqs_rt;
        logic [CTRL_W-1:0] ctrl;
        logic [7:0] pre_cnt;
        logic [31:0] rdata;
        logic rdy;
        logic err;
    } st_t;

    st_t st_ff;
    st_t nxt_st;

    logic clk_lvl;
    logic clk_rise;
    logic ce;
    logic lsr;
    logic ddr;
    logic sys_lvl;
    logic sys_edge;
    logic pre_now;
    logic dqs_lvl;

    // one of four routing lines, optionally inverted
    function automatic logic pick(input logic [3:0] v, input logic [1:0] s, input logic inv);
        return v[s] ^ inv;
    endfunction

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = {wr_data_neg, wr_data_pos, rd_data_pad, tristate_pos_phase_in,
                     tristate_neg_phase_in, global_tristate_in, dqs_idle, dqs_pad_in,
                     route_ctl, route_clk};
        nxt_st.s2 = st_ff.s1;

        // code word only taken once two samples agree, so a loop update mid-change is skipped
        nxt_st.c1 = st_ff.ctrl[CTRL_HALF] ? dll_code_b : dll_code_a;
        nxt_st.c2 = st_ff.c1;
        nxt_st.cprev = st_ff.c2;
        if (st_ff.c2 == st_ff.cprev) begin
            nxt_st.code = st_ff.c2;
        end

        ddr = st_ff.ctrl[CTRL_DDR];
        dqs_lvl = st_ff.s2[I_DQS];
        clk_lvl = (st_ff.ctrl[CTRL_SRC_DQS] ? dqs_lvl
                   : st_ff.s2[I_RCLK + 32'(st_ff.ctrl[CTRL_CLK_SEL])])
                  ^ st_ff.ctrl[CTRL_CLK_INV];
        clk_rise = clk_lvl & ~st_ff.clk_prev;
        nxt_st.clk_prev = clk_lvl;
        ce = pick(st_ff.s2[I_CTL +: 4], st_ff.ctrl[CTRL_CE_SEL +: 2],
                  st_ff.ctrl[CTRL_CE_INV]);
        lsr = pick(st_ff.s2[I_CTL +: 4], st_ff.ctrl[CTRL_LSR_SEL +: 2],
                   st_ff.ctrl[CTRL_LSR_INV]);

        nxt_st.gts = st_ff.s2[I_GTS];

        if (lsr) begin
            nxt_st.tri_reg = TRI_RST;
            nxt_st.tri_lat = TRI_RST;
            nxt_st.wr_reg = 1'b0;
            nxt_st.wr_lat = 1'b0;
        end else if (ce) begin
            if (ddr) begin
                if (clk_rise) begin
                    nxt_st.tri_reg = st_ff.s2[I_TNEG];
                    nxt_st.wr_reg = st_ff.s2[I_WNEG];
                end
                if (!clk_lvl) begin
                    nxt_st.tri_lat = st_ff.s2[I_TPOS];
                    nxt_st.wr_lat = st_ff.s2[I_WPOS];
                end
            end else if (st_ff.ctrl[CTRL_LATCH] ? !clk_lvl : clk_rise) begin
                nxt_st.tri_reg = st_ff.s2[I_TNEG];
                nxt_st.wr_reg = st_ff.s2[I_WNEG];
            end
        end
        // output mux follows the i/o clock phase in ddr, storage element alone in sdr
        nxt_st.tri_out = (ddr && clk_lvl) ? nxt_st.tri_lat : nxt_st.tri_reg;
        nxt_st.wr_out = (ddr && clk_lvl) ? nxt_st.wr_lat : nxt_st.wr_reg;

        // strobe routing and read-side ddr capture on delayed dqs edges
        nxt_st.dqs_rt = DQS_CAPABLE & dqs_lvl;
        nxt_st.dqs_prev = dqs_lvl;
        if (dqs_lvl && !st_ff.dqs_prev) begin
            nxt_st.in_pos = st_ff.s2[I_RD];
        end
        if (!dqs_lvl && st_ff.dqs_prev) begin
            nxt_st.in_neg = st_ff.s2[I_RD];
        end

        // preamble: strobe leaves termination level while driven low
        pre_now = st_ff.idle_prev & ~st_ff.s2[I_IDLE] & ~dqs_lvl;
        nxt_st.idle_prev = st_ff.s2[I_IDLE];
        nxt_st.pre = pre_now;
        if (pre_now) begin
            nxt_st.pre_cnt = st_ff.pre_cnt + 8'h01;
        end

        // system clock is routing clock 0; high at preamble means capture on its fall
        sys_lvl = st_ff.s2[I_RCLK];
        nxt_st.sys_prev = sys_lvl;
        if (lsr) begin
            nxt_st.pol = st_ff.ctrl[CTRL_DEF_POL];
        end else if (pre_now) begin
            nxt_st.pol = sys_lvl;
        end
        sys_edge = st_ff.pol ? (~sys_lvl & st_ff.sys_prev) : (sys_lvl & ~st_ff.sys_prev);
        if (sys_edge) begin
            nxt_st.sync_pos = st_ff.in_pos;
            nxt_st.sync_neg = st_ff.in_neg;
        end

        // apb: answer in the first access cycle, data and error prepared in setup
        nxt_st.rdy = psel & ~penable;
        if (psel && !penable) begin
            nxt_st.err = (paddr != CTRL_OFF) && (paddr != STAT_OFF);
            nxt_st.rdata = '0;
            if (!pwrite && paddr == CTRL_OFF) begin
                nxt_st.rdata[CTRL_W-1:0] = st_ff.ctrl;
            end else if (!pwrite && paddr == STAT_OFF) begin
                nxt_st.rdata[STAT_POL] = st_ff.pol;
                nxt_st.rdata[STAT_TRI] = st_ff.tri_out;
                nxt_st.rdata[STAT_WR] = st_ff.wr_out;
                nxt_st.rdata[STAT_GTS] = st_ff.gts;
                nxt_st.rdata[STAT_CODE +: CODE_W] = st_ff.code;
                nxt_st.rdata[STAT_CNT +: 8] = st_ff.pre_cnt;
            end
        end
        if (psel && penable && st_ff.rdy && pwrite && paddr == CTRL_OFF) begin
            nxt_st.ctrl = pwdata[CTRL_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
            st_ff.ctrl <= CTRL_RST;
            st_ff.tri_reg <= TRI_RST;
            st_ff.tri_lat <= TRI_RST;
            st_ff.tri_out <= TRI_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.rdata;
    assign pready = st_ff.rdy;
    assign pslverr = st_ff.err;
    assign buffer_tristate_out = st_ff.tri_out;
    assign global_tristate_out = st_ff.gts;
    assign wr_data_out = st_ff.wr_out;
    assign dqs_strobe_out = st_ff.dqs_rt;
    assign delay_code_out = st_ff.code;
    assign rd_sync_pos = st_ff.sync_pos;
    assign rd_sync_neg = st_ff.sync_neg;
    assign read_polarity = st_ff.pol;
    assign preamble_pulse = st_ff.pre;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    sequence s_idle_to_low;
        st_ff.s2[I_IDLE] ##1 (!st_ff.s2[I_IDLE] && !st_ff.s2[I_DQS]);
    endsequence

    property p_apb;
        s_setup ##1 s_access |=> !pready;
    endproperty
    a_apb: assert property (p_apb) else $error("apb answer not one cycle");

    property p_apb_ready;
        s_setup |=> pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("apb ready missing");

    property p_gts;
        ##3 global_tristate_out == $past(global_tristate_in, 3);
    endproperty
    a_gts: assert property (p_gts) else $error("global tristate altered");

    property p_sdr_ff;
        !ddr && !st_ff.ctrl[CTRL_LATCH] && ce && clk_rise && !lsr
            |=> buffer_tristate_out == $past(st_ff.s2[I_TNEG]);
    endproperty
    a_sdr_ff: assert property (p_sdr_ff) else $error("sdr flop not loaded");

    property p_sdr_hold;
        !ddr && !st_ff.ctrl[CTRL_LATCH] && !clk_rise && !lsr |=> $stable(buffer_tristate_out);
    endproperty
    a_sdr_hold: assert property (p_sdr_hold) else $error("sdr output moved");

    property p_latch;
        ddr && clk_lvl && !lsr |=> $stable(st_ff.tri_lat);
    endproperty
    a_latch: assert property (p_latch) else $error("latch not holding");

    property p_ddr_mux;
        ddr && clk_lvl && !lsr |=> buffer_tristate_out == $past(st_ff.tri_lat);
    endproperty
    a_ddr_mux: assert property (p_ddr_mux) else $error("ddr mux wrong phase");

    property p_pre;
        s_idle_to_low |=> preamble_pulse;
    endproperty
    a_pre: assert property (p_pre) else $error("preamble missed");

    property p_pol;
        pre_now && !lsr |=> read_polarity == $past(sys_lvl);
    endproperty
    a_pol: assert property (p_pol) else $error("polarity not set");

    property p_pol_hold;
        !pre_now && !lsr |=> $stable(read_polarity);
    endproperty
    a_pol_hold: assert property (p_pol_hold) else $error("polarity moved");

    property p_lsr;
        lsr |=> read_polarity == $past(st_ff.ctrl[CTRL_DEF_POL]);
    endproperty
    a_lsr: assert property (p_lsr) else $error("default polarity lost");

    property p_cal;
        st_ff.c2 == st_ff.cprev |=> delay_code_out == $past(st_ff.c2);
    endproperty
    a_cal: assert property (p_cal) else $error("delay code not taken");

    property p_sync;
        sys_edge |=> rd_sync_pos == $past(st_ff.in_pos) && rd_sync_neg == $past(st_ff.in_neg);
    endproperty
    a_sync: assert property (p_sync) else $error("sync register missed edge");

    property p_pre_once;
        preamble_pulse |=> !preamble_pulse;
    endproperty
    a_pre_once: assert property (p_pre_once) else $error("preamble pulse too long");

    property p_tri_lsr;
        lsr |=> buffer_tristate_out == TRI_RST;
    endproperty
    a_tri_lsr: assert property (p_tri_lsr) else $error("local reset missed tristate");

    property p_wr_lsr;
        lsr |=> !wr_data_out;
    endproperty
    a_wr_lsr: assert property (p_wr_lsr) else $error("local reset missed write data");

    property p_strobe;
        1'b1 |=> dqs_strobe_out == (DQS_CAPABLE & $past(dqs_lvl));
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe routing wrong");

    property p_sdr_latch;
        !ddr && st_ff.ctrl[CTRL_LATCH] && ce && !clk_lvl && !lsr
            |=> buffer_tristate_out == $past(st_ff.s2[I_TNEG]);
    endproperty
    a_sdr_latch: assert property (p_sdr_latch) else $error("sdr latch not open");

    property p_ddr_reg;
        ddr && ce && clk_rise && !lsr |=> st_ff.tri_reg == $past(st_ff.s2[I_TNEG]);
    endproperty
    a_ddr_reg: assert property (p_ddr_reg) else $error("ddr register not loaded");

    property p_ddr_low;
        ddr && !clk_lvl && !lsr |=> buffer_tristate_out == $past(st_ff.tri_reg);
    endproperty
    a_ddr_low: assert property (p_ddr_low) else $error("ddr low phase wrong");

    property p_half;
        st_ff.ctrl[CTRL_HALF] |=> st_ff.c1 == $past(dll_code_b);
    endproperty
    a_half: assert property (p_half) else $error("wrong loop code taken");

    property p_apb_err;
        s_setup |=> pslverr == ($past(paddr) != CTRL_OFF && $past(paddr) != STAT_OFF);
    endproperty
    a_apb_err: assert property (p_apb_err) else $error("apb error flag wrong");

    property p_ctrl_wr;
        s_setup ##1 (psel && penable && pready && pwrite && paddr == CTRL_OFF)
            |=> st_ff.ctrl == $past(pwdata[CTRL_W-1:0]);
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");

endmodule

// ### testbench/ddr_mem_model.sv
// far-side memory model: read strobe with preamble, burst and release
`timescale 1ns/10ps
module ddr_mem_model (
    input wire logic go,
    input wire logic slow,
    output logic dqs_pad_in,
    output logic dqs_idle,
    output logic rd_data_pad,
    output logic busy
);
    initial begin
        dqs_idle = 1'h1;
        dqs_pad_in = 1'h1;
        rd_data_pad = 1'h0;
        busy = 1'h0;
    end
    always @(posedge go) begin
        busy = 1'h1;
        #(slow ? 600 : 250); // strobe left to termination before the read
        dqs_pad_in = 1'h0; // preamble starts driven low
        dqs_idle = 1'h0;
        #125;
        repeat (8) begin
            rd_data_pad = ~rd_data_pad;
            #31.25 dqs_pad_in = ~dqs_pad_in;
            #31.25;
        end
        #62.5;
        // released lines hold nothing: show the inverse of the last level
        dqs_idle = 1'h1;
        dqs_pad_in = ~dqs_pad_in;
        rd_data_pad = ~rd_data_pad;
        busy = 1'h0;
    end
endmodule

// ### testbench/tb.sv
// self-checking bench: apb access, tristate path, control select, strobe and polarity
`timescale 1ns/10ps
module tb;
    import ddr_io_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, err;
    logic [1:0] route_clk = 0, div = 0, seen;
    logic [3:0] route_ctl = 0;
    logic global_tristate_in = 0, tristate_neg_phase_in = 1, tristate_pos_phase_in = 1;
    logic wr_data_pos = 1, wr_data_neg = 0, go = 0, slow = 0, rclk_run = 0;
    logic [5:0] dll_code_a = 6'h15, dll_code_b = 6'h2a, delay_code_out;
    logic dqs_pad_in, dqs_idle, rd_data_pad, busy, strobe_q;
    logic buffer_tristate_out, global_tristate_out, wr_data_out, dqs_strobe_out;
    logic rd_sync_pos, rd_sync_neg, read_polarity, preamble_pulse;
    int n_fail = 0, total_checks = 0, cyc = 0, rises = 0;

    always #4 pclk = ~pclk;

    ddr_io_tristate_dqs_polarity dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .route_clk, .route_ctl, .dqs_pad_in, .dqs_idle,
        .global_tristate_in, .tristate_neg_phase_in, .tristate_pos_phase_in, .rd_data_pad,
        .wr_data_pos, .wr_data_neg, .dll_code_a, .dll_code_b, .buffer_tristate_out,
        .global_tristate_out, .wr_data_out, .dqs_strobe_out, .delay_code_out, .rd_sync_pos,
        .rd_sync_neg, .read_polarity, .preamble_pulse);

    ddr_mem_model mdl (.go, .slow, .dqs_pad_in, .dqs_idle, .rd_data_pad, .busy);

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // routing clock runs slow enough for the sampled io clock path
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        strobe_q <= dqs_strobe_out;
        div <= div + 2'h1;
        if (rclk_run && div == 2'h3)
            route_clk[0] <= ~route_clk[0];
        if (busy && dqs_strobe_out === 1'h1 && strobe_q === 1'h0)
            rises <= rises + 1;
        if (cyc == 5000) begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic tick(input int k);
        repeat (k) @(posedge pclk);
    endtask

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        penable <= 1'h0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    task automatic do_read(input logic s, input logic [31:0] pol);
        slow <= s;
        go <= 1'h1;
        rises = 0;
        repeat (300) begin
            @(posedge pclk);
            if (preamble_pulse === 1'h1)
                break;
        end
        go <= 1'h0;
        chk("preamble", preamble_pulse, 32'h1);
        chk("polarity", read_polarity, pol);
        repeat (300) begin
            @(posedge pclk);
            if (!busy)
                break;
        end
        tick(4);
        chk("strobe rises", rises, 32'h4);
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, CTRL_OFF, 32'h0);
        chk("ctrl reset", rd, 32'h220);
        chk("tri reset", buffer_tristate_out, 32'h1);
        apb(1'h1, 8'h08, 32'hffff_ffff);
        chk("unmapped", err, 32'h1);
        global_tristate_in <= 1'h1;
        tick(5);
        chk("gts", global_tristate_out, 32'h1);
        chk("code a", delay_code_out, 32'h15);
        apb(1'h1, CTRL_OFF, 32'ha20);
        tick(5);
        chk("code b", delay_code_out, 32'h2a);
        apb(1'h0, STAT_OFF, 32'h0);
        chk("stat code", rd[13:8], 32'h2a);
        $display("test control done");
        apb(1'h1, CTRL_OFF, 32'h220);
        tristate_neg_phase_in <= 1'h0;
        wr_data_neg <= 1'h1;
        rclk_run <= 1'h1;
        tick(24);
        chk("sdr flop", buffer_tristate_out, 32'h0);
        chk("wr sdr", wr_data_out, 32'h1);
        route_ctl[0] <= 1'h1;
        tristate_neg_phase_in <= 1'h1;
        tick(24);
        chk("ce off", buffer_tristate_out, 32'h0);
        route_ctl[0] <= 1'h0;
        tick(24);
        chk("ce on", buffer_tristate_out, 32'h1);
        apb(1'h1, CTRL_OFF, 32'h221);
        tristate_neg_phase_in <= 1'h0;
        tick(8);
        seen = 2'h0;
        repeat (16) begin
            @(posedge pclk);
            seen[buffer_tristate_out] = 1'h1;
        end
        chk("ddr mux", seen, 32'h3);
        rclk_run <= 1'h0;
        tick(1);
        route_clk[0] <= 1'h0;
        apb(1'h1, CTRL_OFF, 32'h222);
        tristate_neg_phase_in <= 1'h1;
        tick(6);
        chk("latch open", buffer_tristate_out, 32'h1);
        tristate_neg_phase_in <= 1'h0;
        tick(6);
        chk("latch follow", buffer_tristate_out, 32'h0);
        apb(1'h1, CTRL_OFF, 32'h220);
        tristate_neg_phase_in <= 1'h1;
        tick(6);
        chk("flop hold", buffer_tristate_out, 32'h0);
        tristate_neg_phase_in <= 1'h0;
        route_clk[0] <= 1'h1;
        tick(8);
        apb(1'h1, CTRL_OFF, 32'h232);
        tristate_neg_phase_in <= 1'h1;
        tick(6);
        chk("clk inv", buffer_tristate_out, 32'h1);
        tristate_neg_phase_in <= 1'h0;
        route_ctl[1] <= 1'h1;
        tick(6);
        chk("lsr on", buffer_tristate_out, 32'h1);
        apb(1'h1, CTRL_OFF, 32'h272);
        tick(6);
        chk("lsr inv", buffer_tristate_out, 32'h0);
        route_ctl[1] <= 1'h0;
        apb(1'h1, CTRL_OFF, 32'h220);
        $display("test tristate done");
        do_read(1'h0, 32'h1);
        route_clk[0] <= 1'h0;
        tick(4);
        chk("sync pos fall", rd_sync_pos, 32'h1);
        chk("sync neg fall", rd_sync_neg, 32'h0);
        do_read(1'h1, 32'h0);
        route_clk[0] <= 1'h1;
        tick(4);
        chk("sync pos rise", rd_sync_pos, 32'h0);
        chk("sync neg rise", rd_sync_neg, 32'h1);
        apb(1'h0, STAT_OFF, 32'h0);
        chk("preamble count", rd[23:16], 32'h2);
        apb(1'h1, CTRL_OFF, 32'h1220);
        route_ctl[1] <= 1'h1;
        tick(6);
        chk("default pol", read_polarity, 32'h1);
        route_ctl[1] <= 1'h0;
        $display("test read done");
        give_verdict();
    end
endmodule
